// *** bus_cycle_pkg.sv ***
package bus_cycle_pkg;

  localparam int BUS_W = 32;
  localparam int WORD_ADDR_W = 30;
  localparam int LEN_W = 2;
  localparam int SIZE_LSB = 0;
  localparam int WORD_ADDR_LSB = 2;
  localparam int SYNC_STAGES = 2;

  // Burst length as carried on the two low bus bits in the address state
  localparam logic [1:0] LEN_ONE = 2'h0;
  localparam logic [1:0] LEN_TWO = 2'h1;
  localparam logic [1:0] LEN_THREE = 2'h2;
  localparam logic [1:0] LEN_FOUR = 2'h3;

  localparam logic DIR_RECEIVE = 1'b0;
  localparam logic DIR_TRANSMIT = 1'b1;

  typedef enum logic [1:0]
  {
    KIND_READ = 2'h0,
    KIND_WRITE = 2'h1,
    KIND_INTACK = 2'h2
  } kind_t;

  typedef enum logic [3:0]
  {
    ST_IDLE = 4'h1,
    ST_LOCK_WAIT = 4'h2,
    ST_ADDR = 4'h4,
    ST_DATA = 4'h8
  } state_t;

  typedef struct packed
  {
    logic [WORD_ADDR_W-1:0] word_addr;
    logic [LEN_W-1:0] len;
    kind_t kind;
    logic rmw;
  } req_t;

endpackage

// *** rmw_lock_ctrl.sv ***
`timescale 1ns/1ns
module rmw_lock_ctrl
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic lock_n_in,
  input wire logic lock_set,
  input wire logic lock_release,
  output logic lock_busy,
  output logic lock_n_out,
  output logic lock_oe_n
);

  logic own;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      own <= 1'b0;
    else if (ce)
    begin
      if (lock_set)
        own <= 1'b1; // [RULE_12] [RULE_14]
      else if (lock_release)
        own <= 1'b0; // [RULE_12]
    end
  end

  // Shared open-drain line: only pull low, never drive high
  assign lock_n_out = 1'b0; // [RULE_10]
  assign lock_oe_n = ~own;
  // Another agent holds the line while ours is released
  assign lock_busy = ~lock_n_in & ~own; // [RULE_09] [RULE_10]

endmodule

// *** local_bus_cycle_control.sv ***
`timescale 1ns/1ns
// Notes on behaviour
// RULE_01: Address strobe low in every address state, high in the next data.
// RULE_02: In bursts, strobe low again in data states after a ready cycle.
// RULE_03: Write/read level set in address state, held through all data states.
// RULE_04: Direction low for reads and interrupt acknowledges, high for writes.
// RULE_05: Direction never changes while transceiver enable is asserted.
// RULE_06: Transceiver enable asserted (low) in every data and wait state.
// RULE_07: Far agent gives ready only when data may be sampled or removed.
// RULE_08: No ready in a data state adds a wait state, strobe stays high.
// RULE_09: While lock is held nobody starts a locked read-modify-write.
// RULE_10: Lock line is shared; every agent may pull it and watches it.
// RULE_11: Locked sequence samples lock first and stalls while someone holds it.
// RULE_12: Lock asserted in read address state, released in write address state.
// RULE_13: Other agents may do plain cycles but no locked sequence meanwhile.
// RULE_14: Lock also asserted throughout interrupt-acknowledge transactions.
// RULE_15: Address state carries word address on bits 2-31; data uses all bits.
// RULE_16: Address state carries burst length on the two low bits.
// RULE_17: Address latch strobe low in the address state, high before data.
// RULE_18: After final ready go idle, or straight to a new address state; a locked request that meets a busy lock goes to ST_LOCK_WAIT instead.
module local_bus_cycle_control
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic req_valid,
  output logic req_ready,
  input wire bus_cycle_pkg::req_t req,
  input wire logic [bus_cycle_pkg::BUS_W-1:0] wr_data,
  output logic wr_take,
  output logic [bus_cycle_pkg::BUS_W-1:0] rd_data,
  output logic rd_valid,
  output logic done,
  input wire logic [bus_cycle_pkg::BUS_W-1:0] mux_addr_data_in,
  output logic [bus_cycle_pkg::BUS_W-1:0] mux_addr_data_out,
  output logic mux_addr_data_oe_n,
  output logic address_state_strobe_n,
  output logic address_latch_n,
  output logic write_read,
  output logic transceiver_direction,
  output logic transceiver_enable_n,
  input wire logic ready_n,
  input wire logic lock_n_in,
  output logic lock_n_out,
  output logic lock_oe_n
);

  function automatic logic needs_lock(input bus_cycle_pkg::req_t r);
    needs_lock = (r.kind == bus_cycle_pkg::KIND_INTACK) ||
      (r.kind == bus_cycle_pkg::KIND_READ && r.rmw);
  endfunction

  function automatic logic releases_lock(input bus_cycle_pkg::req_t r);
    releases_lock = (r.kind == bus_cycle_pkg::KIND_WRITE) && r.rmw;
  endfunction

  logic [bus_cycle_pkg::SYNC_STAGES-1:0] rst_pipe;
  logic rst_n;
  bus_cycle_pkg::state_t state;
  bus_cycle_pkg::state_t next_state;
  bus_cycle_pkg::req_t cur;
  bus_cycle_pkg::req_t src;
  logic [bus_cycle_pkg::LEN_W-1:0] words_left;
  logic rebeat;
  logic lock_busy;
  logic take;
  logic beat;
  logic finish;
  logic enter_addr;
  logic is_write;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      rst_pipe <= '0;
    else
      rst_pipe <= {rst_pipe[bus_cycle_pkg::SYNC_STAGES-2:0], 1'b1};
  end
  assign rst_n = rst_pipe[bus_cycle_pkg::SYNC_STAGES-1];

  assign is_write = cur.kind == bus_cycle_pkg::KIND_WRITE;
  assign beat = state == bus_cycle_pkg::ST_DATA && !ready_n;
  assign finish = beat && words_left == bus_cycle_pkg::LEN_ONE;
  // Accept while idle or on the final ready, so cycles can run back to back
  assign req_ready = ce && rst_n &&
    (state == bus_cycle_pkg::ST_IDLE || finish); // [RULE_18]
  assign take = req_valid && req_ready;
  assign src = take ? req : cur;
  // Lock sampled before any locked cycle starts
  assign enter_addr = (take && !(needs_lock(req) && lock_busy)) ||
    (state == bus_cycle_pkg::ST_LOCK_WAIT && !lock_busy); // [RULE_11]

  always_comb
  begin
    next_state = state;
    case (state)
      bus_cycle_pkg::ST_IDLE,
      bus_cycle_pkg::ST_LOCK_WAIT:
        if (enter_addr)
          next_state = bus_cycle_pkg::ST_ADDR;
        else if (take)
          next_state = bus_cycle_pkg::ST_LOCK_WAIT; // [RULE_11]
      bus_cycle_pkg::ST_ADDR:
        next_state = bus_cycle_pkg::ST_DATA;
      bus_cycle_pkg::ST_DATA:
        if (finish)
        begin
          if (enter_addr)
            next_state = bus_cycle_pkg::ST_ADDR; // [RULE_18]
          else if (take)
            next_state = bus_cycle_pkg::ST_LOCK_WAIT;
          else
            next_state = bus_cycle_pkg::ST_IDLE; // [RULE_18]
        end
      default:
        next_state = bus_cycle_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state <= bus_cycle_pkg::ST_IDLE;
    else if (ce)
      state <= next_state; // [RULE_08]
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cur <= '0;
    else if (ce && take)
      cur <= req;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      words_left <= bus_cycle_pkg::LEN_ONE;
      rebeat <= 1'b0;
    end
    else if (ce)
    begin
      if (state == bus_cycle_pkg::ST_ADDR)
        words_left <= cur.len;
      else if (beat && !finish)
        words_left <= words_left - 2'h1;
      // Strobe again only after a ready that did not end the burst
      rebeat <= beat && !finish; // [RULE_02] [RULE_08]
    end
  end

  // Direction and write/read only load on entering an address state,
  // where the transceiver enable is already released
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      write_read <= 1'b0;
      transceiver_direction <= bus_cycle_pkg::DIR_RECEIVE;
    end
    else if (ce && enter_addr)
    begin
      write_read <= src.kind == bus_cycle_pkg::KIND_WRITE; // [RULE_03]
      transceiver_direction <= (src.kind == bus_cycle_pkg::KIND_WRITE) ?
        bus_cycle_pkg::DIR_TRANSMIT :
        bus_cycle_pkg::DIR_RECEIVE; // [RULE_04] [RULE_05]
    end
  end

  // Next write word is fetched when the current one is handed over
  assign wr_take = ce && is_write &&
    (state == bus_cycle_pkg::ST_ADDR || (beat && !finish));

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      mux_addr_data_out <= '0;
    else if (ce)
    begin
      if (enter_addr)
      begin
        mux_addr_data_out[bus_cycle_pkg::BUS_W-1:
          bus_cycle_pkg::WORD_ADDR_LSB] <= src.word_addr; // [RULE_15]
        mux_addr_data_out[bus_cycle_pkg::SIZE_LSB+:
          bus_cycle_pkg::LEN_W] <= src.len; // [RULE_16]
      end
      else if (wr_take)
        mux_addr_data_out <= wr_data; // [RULE_15]
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data <= '0;
      rd_valid <= 1'b0;
      done <= 1'b0;
    end
    else if (ce)
    begin
      if (beat && !is_write)
        rd_data <= mux_addr_data_in; // [RULE_15]
      rd_valid <= beat && !is_write;
      done <= finish;
    end
  end

  assign mux_addr_data_oe_n = !(state == bus_cycle_pkg::ST_ADDR ||
    (state == bus_cycle_pkg::ST_DATA && is_write));
  assign address_state_strobe_n = !(state == bus_cycle_pkg::ST_ADDR ||
    (state == bus_cycle_pkg::ST_DATA && rebeat)); // [RULE_01] [RULE_02]
  assign address_latch_n = state != bus_cycle_pkg::ST_ADDR; // [RULE_17]
  // Wait states are data-state cycles without ready
  assign transceiver_enable_n = state != bus_cycle_pkg::ST_DATA; // [RULE_06]

  rmw_lock_ctrl lock_ctrl
  (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .lock_n_in(lock_n_in),
    .lock_set(enter_addr && needs_lock(src)), // [RULE_12] [RULE_14]
    .lock_release((enter_addr && releases_lock(src)) ||
      (finish && cur.kind == bus_cycle_pkg::KIND_INTACK)), // [RULE_14]
    .lock_busy(lock_busy),
    .lock_n_out(lock_n_out),
    .lock_oe_n(lock_oe_n)
  );

endmodule

// *** local_bus_cycle_control_chk.sv ***
`timescale 1ns/1ns
module local_bus_cycle_control_chk
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire bus_cycle_pkg::req_t req,
  input wire logic ready_n,
  input wire logic lock_n_in,
  input wire logic done,
  input wire logic [bus_cycle_pkg::BUS_W-1:0] mux_addr_data_out,
  input wire logic mux_addr_data_oe_n,
  input wire logic address_state_strobe_n,
  input wire logic address_latch_n,
  input wire logic write_read,
  input wire logic transceiver_direction,
  input wire logic transceiver_enable_n,
  input wire logic lock_oe_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire dat = !transceiver_enable_n;
  wire rdy = dat && !ready_n;
  // Locked requests may stall, so only these have a fixed start
  sequence plain_take;
    req_valid && req_ready && !req.rmw &&
      req.kind != bus_cycle_pkg::KIND_INTACK;
  endsequence
  sequence ready_beat;
    rdy ##1 dat;
  endsequence
  a_addr_fields: assert property (plain_take |=> !address_latch_n &&
    !mux_addr_data_oe_n &&
    mux_addr_data_out == {$past(req.word_addr), $past(req.len)})
    else $error("address state fields wrong");
  // A frozen clock enable holds the address state, so only a live edge counts
  a_addr_to_data: assert property (!address_latch_n && ce |->
    !address_state_strobe_n ##1 address_latch_n && address_state_strobe_n && dat)
    else $error("address state not followed by data state");
  a_burst_restrobe: assert property (ready_beat |-> !address_state_strobe_n)
    else $error("no strobe after burst ready");
  a_wait_state: assert property (dat && ready_n |=> dat && address_state_strobe_n)
    else $error("wait state missing");
  a_dir_frozen: assert property (dat ##1 dat |->
    $stable(transceiver_direction) && $stable(write_read))
    else $error("direction moved while enabled");
  a_dir_matches: assert property ((!address_latch_n || dat) |->
    transceiver_direction == write_read)
    else $error("direction differs from write flag");
  a_lock_grab: assert property ($fell(lock_oe_n) |-> !address_latch_n &&
    !write_read && $past(lock_n_in))
    else $error("lock taken at wrong time");
  a_lock_drop: assert property ($rose(lock_oe_n) |->
    (!address_latch_n && write_read) || $past(rdy))
    else $error("lock released at wrong time");
  a_done_ready: assert property (done |-> $past(rdy))
    else $error("done without ready");
endmodule
bind local_bus_cycle_control local_bus_cycle_control_chk i_chk (.*);

// *** bus_agent_model.sv ***
`timescale 1ns/1ns
module bus_agent_model
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic transceiver_enable_n,
  input wire logic address_latch_n,
  input wire logic transceiver_direction,
  input wire logic [3:0] wait_cnt,
  output logic ready_n,
  output logic [31:0] mux_addr_data_in
);
  logic [3:0] cnt;
  logic [7:0] beat;
  logic [31:0] idle_word;
  wire in_data = !transceiver_enable_n;
  assign ready_n = !(in_data && cnt == wait_cnt);
  // Released lines toggle so stale data cannot pass for a match
  assign mux_addr_data_in = (in_data && !transceiver_direction) ?
    {24'h5A5A00, beat} : idle_word;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt <= 4'h0;
      beat <= 8'h00;
      idle_word <= 32'h0;
    end
    else
    begin
      idle_word <= ~mux_addr_data_in;
      cnt <= (!in_data || !ready_n) ? 4'h0 : cnt + 4'h1;
      if (!address_latch_n)
        beat <= 8'h00;
      else if (in_data && !ready_n)
        beat <= beat + 8'h01;
    end
  end
endmodule

// *** tb_local_bus_cycle_control.sv ***
`timescale 1ns/1ns
`define CHK(w, g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("FAIL %s exp %0h got %0h", w, e, g); end end
module tb_local_bus_cycle_control;
  logic clock = 0, rstn = 0, ce = 1, req_valid = 0, other_lock = 0;
  logic req_ready, wr_take, rd_valid, done, mux_addr_data_oe_n, ready_n;
  logic address_state_strobe_n, address_latch_n, write_read;
  logic transceiver_direction, transceiver_enable_n, lock_n_out, lock_oe_n;
  bus_cycle_pkg::req_t req = '0;
  logic [31:0] wr_data = 32'hC0DE0000, rd_data;
  logic [31:0] mux_addr_data_in, mux_addr_data_out;
  logic [3:0] wait_cnt = 4'h0;
  int errors = 0, total_checks = 0, cycles = 0, widx = 0;
  // Pulled-up wire: low if either party pulls
  wire lock_n_in = !((!lock_oe_n && !lock_n_out) || other_lock);
  always #5 clock = ~clock;
  local_bus_cycle_control i_local_bus_cycle_control (.*);
  bus_agent_model i_bus_agent_model (.*);
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (req_valid && req_ready)
    begin
      widx <= 0;
      wr_data <= 32'hC0DE0000;
    end
    else if (wr_take)
    begin
      widx <= widx + 1;
      wr_data <= 32'hC0DE0001 + 32'(widx);
    end
    if (cycles == 3000)
    begin
      errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic xfer(input bus_cycle_pkg::kind_t k, input logic r,
    input logic [1:0] l, input int w, input int hold);
    int cyc, nb, nr;
    logic lk, pr, wr;
    cyc = 0;
    pr = 0;
    wr = k == bus_cycle_pkg::KIND_WRITE;
    nb = 0;
    nr = 0;
    lk = k == bus_cycle_pkg::KIND_INTACK || (r && k != bus_cycle_pkg::KIND_WRITE);
    @(posedge clock);
    wait_cnt <= 4'(w);
    req_valid <= 1;
    req <= '{{28'hABCDEF1, l}, l, k, r};
    do @(negedge clock); while (!req_ready);
    @(posedge clock);
    req_valid <= 0;
    repeat (hold)
    begin
      @(negedge clock);
      `CHK("latch", address_latch_n, 1'b1)
      `CHK("no grab", lock_oe_n, 1'b1)
    end
    if (hold > 0)
    begin
      @(posedge clock);
      other_lock <= 0;
    end
    while (done !== 1'b1)
    begin
      @(negedge clock);
      cyc++;
      if (!address_latch_n)
      begin
        `CHK("addr", mux_addr_data_out, {req.word_addr, l})
        `CHK("dir", transceiver_direction, k == bus_cycle_pkg::KIND_WRITE)
        `CHK("astrobe", address_state_strobe_n, 1'b0)
        `CHK("aoe", mux_addr_data_oe_n, 1'b0)
      end
      if (!transceiver_enable_n)
      begin
        `CHK("strobe", address_state_strobe_n, !pr)
        `CHK("oe", mux_addr_data_oe_n, !wr)
        `CHK("wr", write_read, wr)
      end
      if (!transceiver_enable_n && lk)
        `CHK("lock", lock_oe_n, 1'b0)
      if (!transceiver_enable_n && !ready_n && write_read)
      begin
        `CHK("wdata", mux_addr_data_out, 32'hC0DE0000 + 32'(nb))
        nb++;
      end
      if (rd_valid)
      begin
        `CHK("rdata", rd_data, {24'h5A5A00, 8'(nr)})
        nr++;
      end
      pr = !transceiver_enable_n && !ready_n;
    end
    if (hold == 0)
      `CHK("cycles", cyc, 2 + (l + 1) * (w + 1))
    if (k == bus_cycle_pkg::KIND_WRITE)
      `CHK("beats", nb, l + 1)
  endtask
  task automatic t_read_waits();
    xfer(bus_cycle_pkg::KIND_READ, 0, 2'h0, 2, 0);
  endtask
  task automatic t_write_burst();
    xfer(bus_cycle_pkg::KIND_WRITE, 0, 2'h1, 1, 0);
  endtask
  task automatic t_len_codes();
    for (int i = 0; i < 4; i++)
      xfer(bus_cycle_pkg::KIND_READ, 0, 2'(i), 0, 0);
  endtask
  task automatic t_locked_rmw();
    @(posedge clock);
    other_lock <= 1;
    xfer(bus_cycle_pkg::KIND_READ, 1, 2'h0, 0, 6);
    xfer(bus_cycle_pkg::KIND_WRITE, 1, 2'h0, 0, 0);
    `CHK("unlock", lock_oe_n, 1'b1)
  endtask
  task automatic t_intack();
    xfer(bus_cycle_pkg::KIND_INTACK, 0, 2'h0, 1, 0);
    `CHK("ack unlock", lock_oe_n, 1'b1)
  endtask
  task automatic t_back_to_back();
    @(posedge clock);
    wait_cnt <= 4'h0;
    req_valid <= 1;
    req <= '{30'h00000AA, 2'h0, bus_cycle_pkg::KIND_READ, 1'b0};
    @(posedge clock);
    req <= '{30'h00000BB, 2'h0, bus_cycle_pkg::KIND_WRITE, 1'b0};
    do @(negedge clock); while (!req_ready);
    @(posedge clock);
    req_valid <= 0;
    @(negedge clock);
    `CHK("b2b done", done, 1'b1)
    `CHK("b2b addr", address_latch_n, 1'b0)
    `CHK("b2b dir", transceiver_direction, 1'b1)
    `CHK("b2b rdata", rd_data, 32'h5A5A0000)
    @(negedge clock);
    `CHK("b2b wdata", mux_addr_data_out, 32'hC0DE0000)
    @(negedge clock);
    `CHK("b2b end", done, 1'b1)
  endtask
  task automatic t_ce_freeze();
    @(posedge clock);
    req_valid <= 1;
    req <= '{30'h0000123, 2'h0, bus_cycle_pkg::KIND_READ, 1'b0};
    @(posedge clock);
    req_valid <= 0;
    ce <= 0;
    repeat (3)
    begin
      @(negedge clock);
      `CHK("frozen", address_state_strobe_n, 1'b0)
    end
    @(posedge clock);
    ce <= 1;
    repeat (3) @(negedge clock);
    `CHK("thaw done", done, 1'b1)
    `CHK("thaw rdata", rd_data, 32'h5A5A0000)
  endtask
  initial
  begin
    repeat (4) @(posedge clock);
    rstn <= 1;
    repeat (3) @(posedge clock);
    t_read_waits();
    t_write_burst();
    t_len_codes();
    t_locked_rmw();
    t_intack();
    t_back_to_back();
    t_ce_freeze();
    print_verdict();
  end
endmodule
